// File: hdl/sdd_pkg.sv
// Package of constants and types for the supply drop detector control logic
package sdd_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned IDX_W      = 4;
  localparam int unsigned IDX_LSB    = 2;

  // ==========================================================================
  // Register word indices (byte address is index times four)
  localparam logic [3:0] IDX_CTRL     = 4'h0;
  localparam logic [3:0] IDX_PERIPHERAL_INT_ENABLE_TWO     = 4'h1;
  localparam logic [3:0] IDX_PERIPHERAL_INT_FLAG_TWO     = 4'h2;
  localparam logic [3:0] IDX_CORE_INTERRUPT_CONTROL   = 4'h3;
  localparam logic [3:0] IDX_EV_STAT  = 4'h4;
  localparam logic [3:0] IDX_EV_CLR   = 4'h5;
  localparam logic [3:0] IDX_EV_EN    = 4'h6;

  // ==========================================================================
  // Field positions
  localparam int unsigned POS_LEVEL_LSB = 0;
  localparam int unsigned LEVEL_W       = 3;
  localparam int unsigned POS_ENABLE    = 4;
  localparam int unsigned POS_REF_STAB  = 5;
  localparam int unsigned POS_DROP_IE   = 2;
  localparam int unsigned POS_DROP_IF   = 2;
  localparam int unsigned POS_GIE       = 7;
  localparam int unsigned POS_PERIPHERAL_INT_ENABLE      = 6;
  localparam int unsigned POS_EV_DROP   = 0;
  localparam int unsigned POS_EV_REF    = 1;
  localparam int unsigned EV_W          = 2;

  // ==========================================================================
  // Reset values and encodings
  localparam logic [7:0] RST_CTRL      = 8'h04;
  localparam logic [7:0] RST_PERIPHERAL_INT_ENABLE_TWO      = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_INT_FLAG_TWO      = 8'h00;
  localparam logic [7:0] RST_CORE_INTERRUPT_CONTROL    = 8'h00;
  localparam logic [2:0] LEVEL_RSVD    = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [1:0] unused_hi;
    logic       ref_stable;
    logic       enable;
    logic       unused_3;
    logic [2:0] level;
  } sdd_ctrl_t;

  typedef struct packed {
    logic       global_int_enable;
    logic       peripheral_int_enable;
    logic       drop_ie;
    logic       drop_if;
  } sdd_irq_t;

  typedef struct packed {
    logic       wr;
    logic [3:0] idx;
  } sdd_dphase_t;

  typedef enum logic [1:0] {
    SDD_OFF      = 2'b00,
    SDD_SETTLING = 2'b01,
    SDD_ARMED    = 2'b11
  } sdd_state_t;

endpackage : sdd_pkg

// File: hdl/sdd_sync2.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module sdd_sync2 (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic d,
  output logic      q
);

  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule : sdd_sync2

// File: hdl/sdd_top.sv
// Supply drop detector control, status and interrupt logic with AHB-Lite slave
//
// Behaviour
// - Comparator falling-supply edge sets drop flag
// - Drop flag stays set until software clears
// - Request needs global, peripheral and local enables
// - Software writing one sets flag like event
// - Three-bit trip level; code zero reserved
// - Enable bit four powers detector and reference
// - Bit five reads reference stable, oscillator running
// - Local and peripheral enables wake core
// - Global enable also sends core to handler
// - Bits seven, six, three ignore writes, read zero
`timescale 1ns/100ps
module sdd_top (
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        CMP_BELOW,
  input  wire logic        REF_READY,
  input  wire logic        FAST_OSC_RUN,
  output logic             DET_ENABLE,
  output logic      [2:0]  TRIP_LEVEL,
  output logic             LEVEL_RESERVED,
  output logic             DET_ARMED,
  output logic             CORE_WAKE,
  output logic             CORE_INT_REQ,
  output logic             IRQ
);

  // ==========================================================================
  // Declarations
  sdd_pkg::sdd_ctrl_t   ctrl_r;
  sdd_pkg::sdd_ctrl_t   ctrl_nxt;
  sdd_pkg::sdd_irq_t    irq_r;
  sdd_pkg::sdd_irq_t    irq_nxt;
  sdd_pkg::sdd_dphase_t dp_r;
  sdd_pkg::sdd_dphase_t dp_nxt;
  sdd_pkg::sdd_state_t  state_r;
  sdd_pkg::sdd_state_t  state_nxt;

  logic                 dp_valid_r;
  logic                 dp_valid_nxt;
  logic [31:0]          hrdata_nxt;
  logic                 hreadyout_nxt;
  logic                 addr_take;
  logic [3:0]           addr_idx;

  logic                 wr_ctrl;
  logic                 wr_peripheral_int_enable_two;
  logic                 wr_peripheral_int_flag_two;
  logic                 wr_core_interrupt_control;
  logic                 wr_ev_clr;
  logic                 wr_ev_en;

  logic                 cmp_sync;
  logic                 ref_sync;
  logic                 below_gated;
  logic                 below_prev_r;
  logic                 below_prev_nxt;
  logic                 drop_edge;
  logic                 ref_stable;
  logic                 ref_prev_r;
  logic                 ref_prev_nxt;

  logic [1:0]           ev_stat_r;
  logic [1:0]           ev_stat_nxt;
  logic [1:0]           ev_en_r;
  logic [1:0]           ev_en_nxt;
  logic [1:0]           ev_set;
  logic [1:0]           ev_clr;

  logic                 det_enable_nxt;
  logic [2:0]           trip_level_nxt;
  logic                 level_rsvd_nxt;
  logic                 det_armed_nxt;
  logic                 core_wake_nxt;
  logic                 core_int_req_nxt;
  logic                 irq_nxt_out;

  // ==========================================================================
  // Comparator and reference synchronisers
  sdd_sync2 u_sync_cmp (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .d     (CMP_BELOW),
    .q     (cmp_sync)
  );

  sdd_sync2 u_sync_ref (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .d     (REF_READY),
    .q     (ref_sync)
  );

  // ==========================================================================
  // AHB-Lite address phase capture
  always_comb begin
    addr_take    = HSEL && (HTRANS == sdd_pkg::HTRANS_NONSEQ) && HREADY;
    addr_idx     = HADDR[sdd_pkg::IDX_LSB +: sdd_pkg::IDX_W];
    dp_valid_nxt = addr_take;
    dp_nxt       = dp_r;
    if (addr_take) begin
      dp_nxt.wr  = HWRITE;
      dp_nxt.idx = addr_idx;
    end
    hreadyout_nxt = 1'b1;
  end

  // Data phase write strobes
  always_comb begin
    wr_ctrl   = dp_valid_r && dp_r.wr && (dp_r.idx == sdd_pkg::IDX_CTRL);
    wr_peripheral_int_enable_two   = dp_valid_r && dp_r.wr && (dp_r.idx == sdd_pkg::IDX_PERIPHERAL_INT_ENABLE_TWO);
    wr_peripheral_int_flag_two   = dp_valid_r && dp_r.wr && (dp_r.idx == sdd_pkg::IDX_PERIPHERAL_INT_FLAG_TWO);
    wr_core_interrupt_control = dp_valid_r && dp_r.wr && (dp_r.idx == sdd_pkg::IDX_CORE_INTERRUPT_CONTROL);
    wr_ev_clr = dp_valid_r && dp_r.wr && (dp_r.idx == sdd_pkg::IDX_EV_CLR);
    wr_ev_en  = dp_valid_r && dp_r.wr && (dp_r.idx == sdd_pkg::IDX_EV_EN);
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      dp_valid_r <= 1'b0;
      dp_r       <= '0;
      HREADYOUT  <= 1'b1;
    end else begin
      dp_valid_r <= dp_valid_nxt;
      dp_r       <= dp_nxt;
      HREADYOUT  <= hreadyout_nxt;
    end
  end

  // ==========================================================================
  // Control register: level, enable; reference status is live
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt.level  = HWDATA[sdd_pkg::POS_LEVEL_LSB +: sdd_pkg::LEVEL_W];
      ctrl_nxt.enable = HWDATA[sdd_pkg::POS_ENABLE];
    end
    ctrl_nxt.unused_hi  = 2'h0;
    ctrl_nxt.unused_3   = 1'b0;
    ctrl_nxt.ref_stable = ref_stable;
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_r <= sdd_pkg::RST_CTRL;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================================
  // Reference stability and drop edge detection
  always_comb begin
    ref_stable     = ref_sync && ctrl_r.enable && FAST_OSC_RUN;
    ref_prev_nxt   = ref_stable;
    below_gated    = cmp_sync && ctrl_r.enable;
    below_prev_nxt = below_gated;
    drop_edge      = below_gated && !below_prev_r;
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      below_prev_r <= 1'b0;
      ref_prev_r   <= 1'b0;
    end else begin
      below_prev_r <= below_prev_nxt;
      ref_prev_r   <= ref_prev_nxt;
    end
  end

  // ==========================================================================
  // Detector state: off, settling, armed
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sdd_pkg::SDD_OFF: begin
        if (ctrl_r.enable) begin
          state_nxt = sdd_pkg::SDD_SETTLING;
        end
      end
      sdd_pkg::SDD_SETTLING: begin
        if (!ctrl_r.enable) begin
          state_nxt = sdd_pkg::SDD_OFF;
        end else if (ref_stable) begin
          state_nxt = sdd_pkg::SDD_ARMED;
        end
      end
      sdd_pkg::SDD_ARMED: begin
        if (!ctrl_r.enable) begin
          state_nxt = sdd_pkg::SDD_OFF;
        end else if (!ref_stable) begin
          state_nxt = sdd_pkg::SDD_SETTLING;
        end
      end
      default: begin
        state_nxt = sdd_pkg::SDD_OFF;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= sdd_pkg::SDD_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Interrupt enables and drop flag
  always_comb begin
    irq_nxt = irq_r;
    if (wr_peripheral_int_enable_two) begin
      irq_nxt.drop_ie = HWDATA[sdd_pkg::POS_DROP_IE];
    end
    if (wr_core_interrupt_control) begin
      irq_nxt.global_int_enable  = HWDATA[sdd_pkg::POS_GIE];
      irq_nxt.peripheral_int_enable = HWDATA[sdd_pkg::POS_PERIPHERAL_INT_ENABLE];
    end
    // Written value loads the flag; a one simulates an event
    if (wr_peripheral_int_flag_two) begin
      irq_nxt.drop_if = HWDATA[sdd_pkg::POS_DROP_IF];
    end
    // Hardware set wins over a same-cycle software clear
    if (drop_edge) begin
      irq_nxt.drop_if = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      irq_r <= '0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================================
  // Block event status, clear and enable
  always_comb begin
    ev_set                        = 2'h0;
    ev_set[sdd_pkg::POS_EV_DROP]  = irq_nxt.drop_if && !irq_r.drop_if;
    ev_set[sdd_pkg::POS_EV_REF]   = ref_stable && !ref_prev_r;
    ev_clr                        = wr_ev_clr ? HWDATA[sdd_pkg::EV_W-1:0] : 2'h0;
    ev_stat_nxt                   = (ev_stat_r & ~ev_clr) | ev_set;
    ev_en_nxt                     = wr_ev_en ? HWDATA[sdd_pkg::EV_W-1:0] : ev_en_r;
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ev_stat_r <= 2'h0;
      ev_en_r   <= 2'h0;
    end else begin
      ev_stat_r <= ev_stat_nxt;
      ev_en_r   <= ev_en_nxt;
    end
  end

  // ==========================================================================
  // Read data, taken from next values so a write is seen at once
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (addr_take && !HWRITE) begin
      case (addr_idx)
        sdd_pkg::IDX_CTRL: begin
          hrdata_nxt[7:0] = ctrl_nxt;
        end
        sdd_pkg::IDX_PERIPHERAL_INT_ENABLE_TWO: begin
          hrdata_nxt[sdd_pkg::POS_DROP_IE] = irq_nxt.drop_ie;
        end
        sdd_pkg::IDX_PERIPHERAL_INT_FLAG_TWO: begin
          hrdata_nxt[sdd_pkg::POS_DROP_IF] = irq_nxt.drop_if;
        end
        sdd_pkg::IDX_CORE_INTERRUPT_CONTROL: begin
          hrdata_nxt[sdd_pkg::POS_GIE]  = irq_nxt.global_int_enable;
          hrdata_nxt[sdd_pkg::POS_PERIPHERAL_INT_ENABLE] = irq_nxt.peripheral_int_enable;
        end
        sdd_pkg::IDX_EV_STAT: begin
          hrdata_nxt[sdd_pkg::EV_W-1:0] = ev_stat_nxt;
        end
        sdd_pkg::IDX_EV_EN: begin
          hrdata_nxt[sdd_pkg::EV_W-1:0] = ev_en_nxt;
        end
        default: begin
          hrdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      HRDATA <= 32'h0000_0000;
      HRESP  <= sdd_pkg::HRESP_OKAY;
    end else begin
      HRDATA <= hrdata_nxt;
      HRESP  <= sdd_pkg::HRESP_OKAY;
    end
  end

  // ==========================================================================
  // Analog controls, wake and interrupt outputs
  always_comb begin
    det_enable_nxt   = ctrl_nxt.enable;
    trip_level_nxt   = ctrl_nxt.level;
    level_rsvd_nxt   = (ctrl_nxt.level == sdd_pkg::LEVEL_RSVD);
    det_armed_nxt    = (state_nxt == sdd_pkg::SDD_ARMED);
    core_wake_nxt    = irq_nxt.drop_if && irq_nxt.drop_ie && irq_nxt.peripheral_int_enable;
    core_int_req_nxt = core_wake_nxt && irq_nxt.global_int_enable;
    irq_nxt_out      = |(ev_stat_nxt & ev_en_nxt);
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      DET_ENABLE     <= 1'b0;
      TRIP_LEVEL     <= sdd_pkg::RST_CTRL[2:0];
      LEVEL_RESERVED <= 1'b0;
      DET_ARMED      <= 1'b0;
      CORE_WAKE      <= 1'b0;
      CORE_INT_REQ   <= 1'b0;
      IRQ            <= 1'b0;
    end else begin
      DET_ENABLE     <= det_enable_nxt;
      TRIP_LEVEL     <= trip_level_nxt;
      LEVEL_RESERVED <= level_rsvd_nxt;
      DET_ARMED      <= det_armed_nxt;
      CORE_WAKE      <= core_wake_nxt;
      CORE_INT_REQ   <= core_int_req_nxt;
      IRQ            <= irq_nxt_out;
    end
  end

endmodule : sdd_top

// File: dv/sdd_top_assertions.sv
// Port-level concurrent checks for the supply drop detector block
`timescale 1ns/100ps
module sdd_chk (
  input wire logic        CLOCK,
  input wire logic        RST_B,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        CMP_BELOW,
  input wire logic        DET_ENABLE,
  input wire logic [2:0]  TRIP_LEVEL,
  input wire logic        LEVEL_RESERVED,
  input wire logic        CORE_WAKE,
  input wire logic        CORE_INT_REQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // ==========================================================================
  // Bus decode
  wire take    = HSEL && HTRANS == sdd_pkg::HTRANS_NONSEQ && HREADY;
  wire wr_any  = take && HWRITE;
  wire at_ctrl = HADDR[5:2] == sdd_pkg::IDX_CTRL;
  wire wr_ctrl = wr_any && at_ctrl;
  wire rd_ctrl = take && !HWRITE && at_ctrl;
  // Global enable as last written over the bus
  logic wr_gie_dp;
  logic gie_seen;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wr_gie_dp <= 1'b0;
      gie_seen  <= 1'b0;
    end else begin
      wr_gie_dp <= wr_any && HADDR[5:2] == sdd_pkg::IDX_CORE_INTERRUPT_CONTROL;
      if (wr_gie_dp) begin
        gie_seen <= HWDATA[sdd_pkg::POS_GIE];
      end
    end
  end
  // ==========================================================================
  // Assertions
  chk_level_rsvd: assert property (
    LEVEL_RESERVED == (TRIP_LEVEL == sdd_pkg::LEVEL_RSVD)) else $error("reserved flag wrong");
  chk_level_hold: assert property (
    $changed(TRIP_LEVEL) || $changed(DET_ENABLE) |-> $past(wr_ctrl, 2))
    else $error("control outputs moved without a write");
  chk_ctrl_write: assert property (
    wr_ctrl ##1 1'b1 |=> TRIP_LEVEL == $past(HWDATA[2:0]) && DET_ENABLE == $past(HWDATA[4]))
    else $error("control write not applied");
  chk_rd_zero: assert property (
    rd_ctrl |=> HRDATA[7:6] == 2'h0 && !HRDATA[3] && HRDATA[31:8] == 24'h0)
    else $error("unimplemented control bits not zero");
  chk_ref_off: assert property (
    rd_ctrl && !DET_ENABLE ##1 !DET_ENABLE |-> HRDATA[5] == 1'b0)
    else $error("reference stable while disabled");
  chk_int_gate: assert property (
    CORE_INT_REQ == (CORE_WAKE && gie_seen)) else $error("request not gated by enables");
  chk_wake_sticky: assert property (
    $fell(CORE_WAKE) |-> $past(wr_any, 2)) else $error("flag dropped without a write");
  chk_wake_cause: assert property (
    $rose(CORE_WAKE) |-> $past(wr_any, 2) || $past(wr_any, 3) || $past(CMP_BELOW, 3) && DET_ENABLE)
    else $error("wake without a cause");
endmodule : sdd_chk

bind sdd_top sdd_chk u_chk (.CLOCK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY,
  .HRDATA, .CMP_BELOW, .DET_ENABLE, .TRIP_LEVEL, .LEVEL_RESERVED, .CORE_WAKE, .CORE_INT_REQ);

// File: dv/sdd_top_tb.sv
// Self-checking bench for the supply drop detector block
`timescale 1ns/100ps
module sdd_top_tb;
  logic        CLOCK = 1'b0;
  logic        RST_B = 1'b0;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [2:0]  HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic        CMP_BELOW = 1'b0;
  logic        REF_READY = 1'b0;
  logic        FAST_OSC_RUN = 1'b1;
  wire  [31:0] HRDATA;
  wire         HREADYOUT, HRESP, DET_ENABLE, LEVEL_RESERVED, DET_ARMED;
  wire         CORE_WAKE, CORE_INT_REQ, IRQ;
  wire  [2:0]  TRIP_LEVEL;
  wire  [8:0]  pins = {DET_ENABLE, TRIP_LEVEL, LEVEL_RESERVED, DET_ARMED, CORE_WAKE,
                       CORE_INT_REQ, IRQ};
  logic        en = 1'b0, flag = 1'b0, ie = 1'b0, global_int_enable = 1'b0, peripheral_int_enable = 1'b0;
  logic        ref_m = 1'b0, cmp_m = 1'b0, rd_dp = 1'b0;
  logic [2:0]  lvl = 3'h4;
  logic [1:0]  evs = 2'h0, eve = 2'h0;
  logic [16:0] notes[$];
  logic [16:0] e;
  int          error_cnt = 0, samples_checked = 0, seed = 49863;

  sdd_top dut (.CLOCK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .CMP_BELOW, .REF_READY, .FAST_OSC_RUN,
    .DET_ENABLE, .TRIP_LEVEL, .LEVEL_RESERVED, .DET_ARMED, .CORE_WAKE, .CORE_INT_REQ, .IRQ);

  always #20 CLOCK = ~CLOCK;

  // ==========================================================================
  // Expected values
  function automatic logic [7:0] exp_rd(input logic [3:0] i);
    case (i)
      4'h0: return {2'h0, ref_m, en, 1'b0, lvl};
      4'h1: return {5'h0, ie, 2'h0};
      4'h2: return {5'h0, flag, 2'h0};
      4'h3: return {global_int_enable, peripheral_int_enable, 6'h0};
      4'h4: return {6'h0, evs};
      4'h6: return {6'h0, eve};
      default: return 8'h0;
    endcase
  endfunction : exp_rd

  // Armed means enabled with a stable reference
  function automatic logic [8:0] exp_pins();
    return {en, lvl, lvl == 3'h0, ref_m, flag & ie & peripheral_int_enable, flag & ie & peripheral_int_enable & global_int_enable,
            |(evs & eve)};
  endfunction : exp_pins

  // ==========================================================================
  // Bus and stimulus tasks
  task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] d);
    HSEL   <= 1'b1;
    HTRANS <= sdd_pkg::HTRANS_NONSEQ;
    HWRITE <= w;
    HADDR  <= {26'h0, i, 2'h0};
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
  endtask : bus

  task automatic settle();
    repeat (4) @(posedge CLOCK);
    evs[1] = evs[1] | (en & REF_READY & FAST_OSC_RUN & ~ref_m);
    ref_m  = en & REF_READY & FAST_OSC_RUN;
    if (en & CMP_BELOW & ~cmp_m) begin
      evs[0] = evs[0] | ~flag;
      flag   = 1'b1;
    end
    cmp_m = en & CMP_BELOW;
  endtask : settle

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [31:0] r;
    r      = $random(seed);
    r[7:0] = d;
    bus(1'b1, i, r);
    case (i)
      4'h0: {en, lvl} = {d[4], d[2:0]};
      4'h1: ie = d[2];
      4'h2: begin
        evs[0] = evs[0] | (d[2] & ~flag);
        flag   = d[2];
      end
      4'h3: {global_int_enable, peripheral_int_enable} = d[7:6];
      4'h5: evs = evs & ~d[1:0];
      4'h6: eve = d[1:0];
      default: ;
    endcase
    if (i == 4'h0) settle();
  endtask : wr

  task automatic rd(input logic [3:0] i);
    notes.push_back({exp_rd(i), exp_pins()});
    bus(1'b0, i, 32'h0);
  endtask : rd

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask : tdone

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Read data monitor
  always @(posedge CLOCK) begin
    if (rd_dp) begin
      e = notes.pop_front();
      samples_checked++;
      if ({HREADYOUT, HRESP, HRDATA, pins} !== {2'h2, 24'h0, e}) begin
        error_cnt++;
        $display("wrong value at %0t: data %h pins %b expected %h", $time, HRDATA, pins, e);
      end
    end
    rd_dp <= HSEL && HTRANS == sdd_pkg::HTRANS_NONSEQ && !HWRITE && HREADYOUT;
  end

  initial begin
    #200000;
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge CLOCK);
    RST_B <= 1'b1;
    @(posedge CLOCK);
    for (int i = 0; i < 16; i++) rd(4'(i));
    tdone("reset");
    for (int c = 0; c < 8; c++) begin
      wr(4'h0, 8'($random(seed)) & 8'hF8 | 8'(c));
      rd(4'h0);
    end
    tdone("levels");
    wr(4'h0, 8'h15);
    REF_READY <= 1'b1;
    settle();
    rd(4'h0);
    rd(4'h4);
    FAST_OSC_RUN <= 1'b0;
    settle();
    rd(4'h0);
    FAST_OSC_RUN <= 1'b1;
    settle();
    wr(4'h5, 8'h03);
    rd(4'h4);
    tdone("reference");
    wr(4'h2, 8'h00);
    wr(4'h6, 8'h01);
    wr(4'h1, 8'h04);
    wr(4'h3, 8'h40);
    rd(4'h2);
    CMP_BELOW <= 1'b1;
    settle();
    rd(4'h2);
    CMP_BELOW <= 1'b0;
    settle();
    rd(4'h2);
    wr(4'h3, 8'hC0);
    rd(4'h3);
    wr(4'h1, 8'h00);
    rd(4'h1);
    wr(4'h2, 8'h00);
    wr(4'h5, 8'h01);
    wr(4'h6, 8'h00);
    wr(4'h1, 8'h04);
    rd(4'h2);
    wr(4'h2, 8'h04);
    rd(4'h4);
    wr(4'h6, 8'h01);
    rd(4'h6);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h5, 8'h03);
    rd(4'h2);
    tdone("interrupts");
    wr(4'h0, 8'h05);
    CMP_BELOW <= 1'b1;
    settle();
    rd(4'h2);
    wr(4'h0, 8'h15);
    rd(4'h2);
    rd(4'h4);
    tdone("disabled");
    repeat (2) @(posedge CLOCK);
    complete_run();
  end
endmodule : sdd_top_tb
